// ===== hw/psl_pkg.sv
// Behaviour
// [R1] Low hardware reset clears whole block; straps sampled; ctrl loads 0x30 on reset instead of clearing
// [R2] Address bit 2 strap, then interrupt output
// [R3] Speed source strap, then MII carrier sense
// [R4] Register access strap, then MII collision
// [R5] Crossover fix strap, then MII data bit 3
// [R6] Address bit 3 strap, then MII data 2
// [R7] Receive isolate strap, then data bit 1
// [R8] Serial mode strap, then fifth LED output
// [R9] Full duplex strap, then data bit 0
// [R10] RMII strap, then RXDV or CRS_DV
// [R11] Speed input high 100M, low 10M
// [R12] Autoneg strap, then MII receive clock
// [R13] Node/repeater strap, then MII receive error
// [R14] Nine event sources can raise interrupt
// [R15] Interrupt asserts as soon as event enabled
// [R16] Each LED shows register-selected event
// [R17] System supplies 50 MHz clock in RMII
// [R18] Strap pair: 1x RMII, 01 SI, 00 MII
// [R19] Isolate strap makes addr1 pin isolate input
// [R20] RMII: two receive bits per valid cycle
// [R21] Straps held until reset; drive after capture
// [R22] MII-only pins undriven outside MII mode
package psl_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_PEND = 8'h08;
    localparam logic [7:0] REG_STRAP = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam int CTL_IRQ_HI = 0;
    localparam int CTL_SPEED = 1;
    localparam int CTL_LED1 = 4;
    localparam int CTL_LEDO4 = 6;
    localparam logic [7:0] CTRL_RST = 8'h30;
    localparam int NUM_EVT = 9;
    // ==========================================
    // LED source codes
    localparam logic [1:0] LED_LINK = 2'h0;
    localparam logic [1:0] LED_COL = 2'h1;
    localparam logic [1:0] LED_ACT = 2'h2;
    localparam logic [1:0] LED_SPEED = 2'h3;
    // ==========================================
    // Shared pin and strap bit positions
    localparam int NUM_PIN = 12;
    localparam int P_IRQ = 0;
    localparam int P_CRS = 1;
    localparam int P_COL = 2;
    localparam int P_RXD3 = 3;
    localparam int P_RXD2 = 4;
    localparam int P_RXD1 = 5;
    localparam int P_LEDO4 = 6;
    localparam int P_RXD0 = 7;
    localparam int P_RXDV = 8;
    localparam int P_RXCLK = 9;
    localparam int P_RXER = 10;
    localparam int P_ADDR1 = 11;
    typedef enum logic [1:0] {MODE_MII, MODE_SI, MODE_RMII} psl_mode_t;
    typedef struct packed {
        logic captured;
        logic [NUM_PIN-1:0] strap;
        psl_mode_t mode;
        logic [7:0] ctrl;
        logic [NUM_EVT-1:0] mask;
        logic [NUM_EVT-1:0] pend;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [NUM_PIN-1:0] pin_o;
        logic [NUM_PIN-1:0] pin_oe;
        logic speed_100;
    } psl_state_t;
    localparam psl_state_t ST_RST = '{ctrl: CTRL_RST, mode: MODE_MII, default: '0};
endpackage : psl_pkg

// ===== hw/psl_strap_pin_mux.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module psl_strap_pin_mux (
    input wire logic pclk, // APB clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [psl_pkg::NUM_EVT-1:0] evt_in, // Event pulses
    input wire logic speed_sel, // Dedicated speed input
    input wire logic link_up, // Link status
    input wire logic activity, // Activity level
    input wire logic rx_valid, // RXDV or CRS_DV source
    input wire logic [3:0] rx_data, // Receive data
    input wire logic rx_crs, // Carrier sense
    input wire logic rx_col, // Collision
    input wire logic rx_clk_lvl, // Receive clock level
    input wire logic rx_err, // Receive error
    input wire logic addr2_or_irq_pin_i, // Pin input
    output logic addr2_or_irq_pin_o, // Pin output
    output logic addr2_or_irq_pin_oe, // Pin enable
    input wire logic crs_pin_i, // Pin input
    output logic crs_pin_o, // Pin output
    output logic crs_pin_oe, // Pin enable
    input wire logic col_pin_i, // Pin input
    output logic col_pin_o, // Pin output
    output logic col_pin_oe, // Pin enable
    input wire logic rxd3_pin_i, // Pin input
    output logic rxd3_pin_o, // Pin output
    output logic rxd3_pin_oe, // Pin enable
    input wire logic rxd2_pin_i, // Pin input
    output logic rxd2_pin_o, // Pin output
    output logic rxd2_pin_oe, // Pin enable
    input wire logic rxd1_pin_i, // Pin input
    output logic rxd1_pin_o, // Pin output
    output logic rxd1_pin_oe, // Pin enable
    input wire logic led_out_4_i, // Pin input
    output logic led_out_4_o, // Pin output
    output logic led_out_4_oe, // Pin enable
    input wire logic rxd0_pin_i, // Pin input
    output logic rxd0_pin_o, // Pin output
    output logic rxd0_pin_oe, // Pin enable
    input wire logic rxdv_pin_i, // Pin input
    output logic rxdv_pin_o, // Pin output
    output logic rxdv_pin_oe, // Pin enable
    input wire logic rxclk_pin_i, // Pin input
    output logic rxclk_pin_o, // Pin output
    output logic rxclk_pin_oe, // Pin enable
    input wire logic rxer_pin_i, // Pin input
    output logic rxer_pin_o, // Pin output
    output logic rxer_pin_oe, // Pin enable
    input wire logic addr1_isolate_led_pin_i, // Pin input
    output logic addr1_isolate_led_pin_o, // Pin output
    output logic addr1_isolate_led_pin_oe, // Pin enable
    output logic [psl_pkg::NUM_PIN-1:0] strap_word, // Latched straps
    output psl_pkg::psl_mode_t iface_mode, // Decoded mode
    output logic speed_100, // Speed in use
    output logic straps_valid // Straps captured
);
    import psl_pkg::*;

    psl_state_t st;
    psl_state_t next_st;
    logic [NUM_PIN-1:0] pin_in;
    logic isolate;
    logic wr_fire;
    logic irq_act;

    // ==========================================
    // Pin gathering
    assign pin_in = {addr1_isolate_led_pin_i, rxer_pin_i, rxclk_pin_i, rxdv_pin_i,
                     rxd0_pin_i, led_out_4_i, rxd1_pin_i, rxd2_pin_i,
                     rxd3_pin_i, col_pin_i, crs_pin_i, addr2_or_irq_pin_i};
    assign isolate = st.strap[P_RXD1] & addr1_isolate_led_pin_i; // [R19]
    assign wr_fire = psel & penable & st.pready & pwrite;

    // LED source select
    function automatic logic led_pick(input logic [1:0] sel, input logic spd);
        logic v;
        v = 1'b0;
        case (sel)
            LED_LINK: v = link_up;
            LED_COL: v = rx_col;
            LED_ACT: v = activity;
            default: v = spd;
        endcase
        return v;
    endfunction : led_pick

    // ==========================================
    // Next state
    always_comb begin
        next_st = st;
        // Strap capture at first edge after reset release
        if (!st.captured) begin
            next_st.captured = 1'b1; // [R1] [R21]
            next_st.strap = pin_in; // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R12] [R13]
            if (pin_in[P_RXDV]) begin
                next_st.mode = MODE_RMII; // [R18]
            end else if (pin_in[P_LEDO4]) begin
                next_st.mode = MODE_SI; // [R18]
            end else begin
                next_st.mode = MODE_MII; // [R18]
            end
        end
        // APB setup decode
        next_st.pready = psel & ~penable;
        if (psel && !penable) begin
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
            if (paddr == REG_CTRL) begin
                next_st.prdata[7:0] = st.ctrl;
            end else if (paddr == REG_MASK) begin
                next_st.prdata[NUM_EVT-1:0] = st.mask;
            end else if (paddr == REG_PEND) begin
                next_st.prdata[NUM_EVT-1:0] = st.pend;
            end else if (paddr == REG_STRAP) begin
                next_st.prdata[NUM_PIN-1:0] = st.strap;
            end else if (paddr == REG_STATE) begin
                next_st.prdata[3:0] = {st.captured, st.speed_100, st.mode};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        // APB write at access completion
        if (wr_fire && paddr == REG_CTRL) begin
            next_st.ctrl = pwdata[7:0];
        end
        if (wr_fire && paddr == REG_MASK) begin
            next_st.mask = pwdata[NUM_EVT-1:0]; // [R14]
        end
        // Sticky events, set wins over clear
        next_st.pend = st.pend | evt_in; // [R14]
        if (wr_fire && paddr == REG_PEND) begin
            next_st.pend = (st.pend & ~pwdata[NUM_EVT-1:0]) | evt_in;
        end
        // Speed source
        if (st.strap[P_CRS]) begin
            next_st.speed_100 = speed_sel; // [R11]
        end else begin
            next_st.speed_100 = st.ctrl[CTL_SPEED];
        end
        // Pin outputs
        irq_act = |(next_st.pend & next_st.mask); // [R15]
        next_st.pin_o = '0;
        next_st.pin_o[P_IRQ] = st.ctrl[CTL_IRQ_HI] ? irq_act : ~irq_act; // [R2]
        next_st.pin_o[P_CRS] = rx_crs; // [R3]
        next_st.pin_o[P_COL] = rx_col; // [R4]
        next_st.pin_o[P_RXD3] = rx_data[3]; // [R5]
        next_st.pin_o[P_RXD2] = rx_data[2]; // [R6]
        next_st.pin_o[P_RXD1] = rx_data[1]; // [R7] [R20]
        next_st.pin_o[P_RXD0] = rx_data[0]; // [R9] [R20]
        next_st.pin_o[P_RXDV] = rx_valid; // [R10]
        next_st.pin_o[P_RXCLK] = rx_clk_lvl; // [R12]
        next_st.pin_o[P_RXER] = rx_err; // [R13]
        next_st.pin_o[P_LEDO4] = led_pick(st.ctrl[CTL_LEDO4+:2], st.speed_100); // [R8] [R16]
        next_st.pin_o[P_ADDR1] = led_pick(st.ctrl[CTL_LED1+:2], st.speed_100); // [R16]
        // Enables only after capture
        next_st.pin_oe = '0;
        if (st.captured) begin
            next_st.pin_oe[P_IRQ] = 1'b1; // [R21]
            next_st.pin_oe[P_LEDO4] = 1'b1;
            next_st.pin_oe[P_ADDR1] = ~st.strap[P_RXD1]; // [R19]
            next_st.pin_oe[P_RXD1] = ~isolate;
            next_st.pin_oe[P_RXD0] = ~isolate;
            next_st.pin_oe[P_RXDV] = ~isolate;
            if (st.mode == MODE_MII) begin
                next_st.pin_oe[P_CRS] = 1'b1; // [R22]
                next_st.pin_oe[P_COL] = 1'b1;
                next_st.pin_oe[P_RXD3] = ~isolate;
                next_st.pin_oe[P_RXD2] = ~isolate;
                next_st.pin_oe[P_RXCLK] = ~isolate;
                next_st.pin_oe[P_RXER] = ~isolate;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RST; // [R1]
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Output wiring from flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign {addr1_isolate_led_pin_o, rxer_pin_o, rxclk_pin_o, rxdv_pin_o,
            rxd0_pin_o, led_out_4_o, rxd1_pin_o, rxd2_pin_o,
            rxd3_pin_o, col_pin_o, crs_pin_o, addr2_or_irq_pin_o} = st.pin_o;
    assign {addr1_isolate_led_pin_oe, rxer_pin_oe, rxclk_pin_oe, rxdv_pin_oe,
            rxd0_pin_oe, led_out_4_oe, rxd1_pin_oe, rxd2_pin_oe,
            rxd3_pin_oe, col_pin_oe, crs_pin_oe, addr2_or_irq_pin_oe} = st.pin_oe;
    assign strap_word = st.strap;
    assign iface_mode = st.mode;
    assign speed_100 = st.speed_100;
    assign straps_valid = st.captured;

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_oe_before_capture: assert property (!st.captured |=> st.pin_oe == '0) // [R21]
        else $error("pin driven before strap capture");
    a_strap_stable: assert property (st.captured |=> $stable(st.strap)) // [R21]
        else $error("strap changed after capture");
    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("apb answer timing wrong");
    a_irq_raise: assert property ((|(evt_in & st.mask)) && !wr_fire
        |=> addr2_or_irq_pin_o == st.ctrl[CTL_IRQ_HI]) // [R15]
        else $error("interrupt not raised on enabled event");
    a_speed_follow: assert property (st.captured && st.strap[P_CRS] && !$rose(st.captured)
        |=> speed_100 == $past(speed_sel)) // [R11]
        else $error("speed does not follow select input");
    a_mii_only_off: assert property (st.captured && st.mode != MODE_MII
        |=> !crs_pin_oe && !col_pin_oe && !rxd3_pin_oe && !rxclk_pin_oe) // [R22]
        else $error("mii pin driven outside mii mode");
    a_rmii_dibit: assert property (st.captured && st.mode == MODE_RMII && !isolate && rx_valid
        |=> rxdv_pin_o && rxdv_pin_oe && rxd1_pin_oe && rxd0_pin_o == $past(rx_data[0])) // [R20]
        else $error("rmii dibit not presented");
    a_iso_led_off: assert property (st.captured && st.strap[P_RXD1]
        |=> !addr1_isolate_led_pin_oe) // [R19]
        else $error("led1 driven in isolate mode");
    a_mode_decode: assert property ($rose(st.captured) |-> iface_mode == (st.strap[P_RXDV] ?
        MODE_RMII : (st.strap[P_LEDO4] ? MODE_SI : MODE_MII))) // [R18]
        else $error("interface mode decode wrong");
    a_pend_clear: assert property (wr_fire && paddr == REG_PEND && pwdata[0] && !evt_in[0]
        |=> !st.pend[0]) // [R14]
        else $error("pending bit not cleared");
endmodule : psl_strap_pin_mux

// ===== verification/psl_mac_model.sv
`timescale 1ns/10ps
// ==========
// MAC receive side
module psl_mac_model (
    input wire logic pclk, // Reference clock
    input wire logic presetn, // Reset, active low
    input wire logic crs_dv, // Valid from the PHY
    input wire logic dv_oe, // Valid pin driven
    input wire logic [1:0] rxd, // Receive dibit
    output int dibit_count, // Dibits taken
    output logic [1:0] last_dibit // Last dibit taken
);
    // Take two bits in each cycle that valid is driven high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dibit_count <= 0;
            last_dibit <= 2'h0;
        end else if (crs_dv && dv_oe) begin
            dibit_count <= dibit_count + 1;
            last_dibit <= rxd;
        end
    end
endmodule : psl_mac_model

// ===== verification/psl_strap_pin_mux_test.sv
`timescale 1ns/10ps
module psl_strap_pin_mux_test;
    import psl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [NUM_EVT-1:0] evt_in = '0;
    logic speed_sel = 0, link_up = 0, activity = 0, rx_valid = 0, rx_crs = 0, rx_col = 0;
    logic rx_clk_lvl = 0, rx_err = 0, speed_100, straps_valid;
    logic [3:0] rx_data = '0;
    logic [NUM_PIN-1:0] pin_in = '0, po, poe, strap_word;
    logic [1:0] last_dibit;
    psl_mode_t iface_mode;
    int num_errors = 0, check_count = 0, dibits;
    // ==========
    // Clock, design and MAC model
    always #4 pclk = ~pclk;
    psl_strap_pin_mux psl_strap_pin_mux_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .speed_sel(speed_sel),
        .link_up(link_up), .activity(activity), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_crs(rx_crs), .rx_col(rx_col), .rx_clk_lvl(rx_clk_lvl), .rx_err(rx_err),
        .addr2_or_irq_pin_i(pin_in[P_IRQ]), .addr2_or_irq_pin_o(po[P_IRQ]),
        .addr2_or_irq_pin_oe(poe[P_IRQ]), .crs_pin_i(pin_in[P_CRS]), .crs_pin_o(po[P_CRS]),
        .crs_pin_oe(poe[P_CRS]), .col_pin_i(pin_in[P_COL]), .col_pin_o(po[P_COL]),
        .col_pin_oe(poe[P_COL]), .rxd3_pin_i(pin_in[P_RXD3]), .rxd3_pin_o(po[P_RXD3]),
        .rxd3_pin_oe(poe[P_RXD3]), .rxd2_pin_i(pin_in[P_RXD2]), .rxd2_pin_o(po[P_RXD2]),
        .rxd2_pin_oe(poe[P_RXD2]), .rxd1_pin_i(pin_in[P_RXD1]), .rxd1_pin_o(po[P_RXD1]),
        .rxd1_pin_oe(poe[P_RXD1]), .led_out_4_i(pin_in[P_LEDO4]), .led_out_4_o(po[P_LEDO4]),
        .led_out_4_oe(poe[P_LEDO4]), .rxd0_pin_i(pin_in[P_RXD0]), .rxd0_pin_o(po[P_RXD0]),
        .rxd0_pin_oe(poe[P_RXD0]), .rxdv_pin_i(pin_in[P_RXDV]), .rxdv_pin_o(po[P_RXDV]),
        .rxdv_pin_oe(poe[P_RXDV]), .rxclk_pin_i(pin_in[P_RXCLK]), .rxclk_pin_o(po[P_RXCLK]),
        .rxclk_pin_oe(poe[P_RXCLK]), .rxer_pin_i(pin_in[P_RXER]), .rxer_pin_o(po[P_RXER]),
        .rxer_pin_oe(poe[P_RXER]), .addr1_isolate_led_pin_i(pin_in[P_ADDR1]),
        .addr1_isolate_led_pin_o(po[P_ADDR1]), .addr1_isolate_led_pin_oe(poe[P_ADDR1]),
        .strap_word(strap_word), .iface_mode(iface_mode), .speed_100(speed_100),
        .straps_valid(straps_valid));
    psl_mac_model psl_mac_model_i (.pclk(pclk), .presetn(presetn), .crs_dv(po[P_RXDV]),
        .dv_oe(poe[P_RXDV]), .rxd({po[P_RXD1], po[P_RXD0]}), .dibit_count(dibits),
        .last_dibit(last_dibit));
    // ==========
    // Shared tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // Start on a rising edge so no signal is driven twice in one step
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            num_errors++;
            print_verdict();
        end
    endtask : apb
    // Apply a strap pattern under reset, then release
    task automatic rst(input logic [11:0] s);
        @(posedge pclk);
        presetn <= 0;
        pin_in <= s;
        repeat (10) @(posedge pclk);
        chk(poe, 0);
        presetn <= 1;
        // Straps must still stand at the capture edge
        @(posedge pclk);
        pin_in <= ~s;
        repeat (2) @(posedge pclk);
        #1 chk(strap_word, s);
        chk(straps_valid, 1);
    endtask : rst
    task automatic evt(input int k);
        @(posedge pclk);
        evt_in <= 9'h001 << k;
        @(posedge pclk);
        evt_in <= '0;
        @(posedge pclk);
        #1;
    endtask : evt
    // ==========
    // Test sequence
    initial begin
        rst(12'hA9D);
        chk(iface_mode, MODE_MII);
        chk(po[P_IRQ], 1);
        chk(poe, 12'hFFF);
        apb(0, REG_STRAP, 0); chk(rd, 32'h0000_0A9D);
        chk(er, 1'b0);
        apb(0, REG_STATE, 0); chk(rd, 32'h0000_0008);
        apb(0, REG_CTRL, 0); chk(rd, 32'h0000_0030);
        apb(1, REG_MASK, 32'hFFFF_FFFF); apb(0, REG_MASK, 0); chk(rd, 32'h0000_01FF);
        apb(0, 8'h14, 0); chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("registers done");
        for (int k = 0; k < NUM_EVT; k++) begin
            evt(k); chk(po[P_IRQ], 0);
            apb(0, REG_PEND, 0); chk(rd, 32'h1 << k);
            apb(1, REG_PEND, 32'h1 << k); #1 chk(po[P_IRQ], 1);
        end
        apb(1, REG_MASK, 0); evt(3); chk(po[P_IRQ], 1);
        apb(1, REG_MASK, 32'h1); apb(1, REG_CTRL, 32'h1); evt(0); chk(po[P_IRQ], 1);
        apb(1, REG_PEND, 32'h1); #1 chk(po[P_IRQ], 0);
        $display("interrupts done");
        for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            rx_data <= p ? 4'h5 : 4'hA;
            {rx_crs, rx_col, rx_clk_lvl, rx_err, rx_valid} <= p ? 5'h00 : 5'h1F;
            repeat (2) @(posedge pclk);
            #1 chk({po[P_RXD3], po[P_RXD2], po[P_RXD1], po[P_RXD0]}, p ? 4'h5 : 4'hA);
            chk({po[P_CRS], po[P_COL], po[P_RXCLK], po[P_RXER], po[P_RXDV]}, p ? 0 : 5'h1F);
        end
        @(posedge pclk);
        link_up <= 1;
        for (int s = 0; s < 2; s++) begin
            apb(1, REG_CTRL, s ? 32'h50 : 32'h0);
            repeat (2) @(posedge pclk);
            #1 chk({po[P_LEDO4], po[P_ADDR1]}, s ? 2'b00 : 2'b11);
        end
        $display("mii pins done");
        rst(12'h040); chk(iface_mode, MODE_SI);
        rst(12'h102); chk(iface_mode, MODE_RMII);
        chk({poe[P_CRS], poe[P_RXD3], poe[P_RXCLK], poe[P_RXD0]}, 4'h1);
        for (int v = 0; v < 2; v++) begin
            @(posedge pclk);
            speed_sel <= v[0];
            repeat (2) @(posedge pclk);
            #1 chk(speed_100, v[0]);
        end
        @(posedge pclk);
        rx_data <= 4'h2;
        rx_valid <= 1;
        repeat (4) @(posedge pclk);
        rx_valid <= 0;
        repeat (3) @(posedge pclk);
        chk(dibits, 4);
        chk(last_dibit, 2'h2);
        $display("rmii done");
        // Isolate strap: addr1 pin becomes an input gating the receive pins
        rst(12'h020); chk(poe, 12'h047);
        chk(iface_mode, MODE_MII);
        @(posedge pclk);
        pin_in[P_ADDR1] <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk(poe, 12'h7FF);
        $display("isolate done");
        print_verdict();
    end
endmodule : psl_strap_pin_mux_test
